// File: fan_model.sv
`timescale 1ns/10ps
`default_nettype none
// Fan load that reports each change of its applied duty and its size.
module fan_model (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire fan_ramp_pkg::duty_t duty,
    output var fan_ramp_pkg::duty_t  step_seen,
    output logic                     moved
);
    import fan_ramp_pkg::*;
    duty_t prev_q;
    // Remember the duty that was applied at the last edge.
    always_ff @(posedge clk) begin
        if (rst) begin
            prev_q <= 8'h00;
        end else begin
            prev_q <= duty;
        end
    end
    // A move is any difference from the duty of the last edge.
    assign moved     = (duty != prev_q);
    assign step_seen = (duty > prev_q) ? duty - prev_q : prev_q - duty;
endmodule : fan_model
`default_nettype wire

// File: fan_pwm_acoustic_ramp.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// RULE1: reset clears ramp control register to zero
// RULE2: bits two to zero set channel c rate
// RULE3: enabled channel steps gradually toward target
// RULE4: codes give steps 1,2,3,5,8,12,24,48
// RULE5: bit three enables channel c smoothing
// RULE6: bits six to four set channel b rate
// RULE7: bit seven enables channel b smoothing
// RULE8: set lock makes register ignore writes
// RULE9: disabled channel applies target duty at once
module fan_pwm_acoustic_ramp #(
    parameter int unsigned STEP_CYCLES = fan_ramp_pkg::SLOT_CYCLES,
    parameter int          CNT_W       = 24
) (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic [7:0]          addr,
    input  wire logic [7:0]          wdata,
    input  wire logic                wr,
    input  wire logic                rd,
    output logic [7:0]               rdata,
    input  wire fan_ramp_pkg::duty_t target_b,
    input  wire fan_ramp_pkg::duty_t target_c,
    output var fan_ramp_pkg::duty_t  fan_drive_b,
    output var fan_ramp_pkg::duty_t  fan_drive_c,
    output logic                     cfg_locked
);
    import fan_ramp_pkg::*;

    logic [7:0]       ctrl_q;
    logic             lock_q;
    logic [7:0]       rdata_q;
    logic [CNT_W-1:0] slot_cnt_q;
    logic             tick_q;
    logic             wr_ctrl;
    logic             wr_lock;

    rate_code_t chan_c_ramp_rate;
    rate_code_t chan_b_ramp_rate;
    logic       chan_c_smooth_enable;
    logic       chan_b_smooth_enable;

    ramp_ch_if ch_if [2] ();

    // Register select; shared by the write path, the read path and checks.
    function automatic logic reg_hit(input logic [7:0] a,
                                     input logic [7:0] off);
        reg_hit = (a == off);
    endfunction : reg_hit

    // Address decode for the two writable registers.
    assign wr_ctrl = wr && reg_hit(addr, RAMP_CTRL_OFF);
    assign wr_lock = wr && reg_hit(addr, CFG_LOCK_OFF);

    // Field extraction from the ramp control register.
    assign chan_c_ramp_rate     = ctrl_q[C_RATE_LSB +: 3]; // [RULE2]
    assign chan_c_smooth_enable = ctrl_q[C_EN_BIT];        // [RULE5]
    assign chan_b_ramp_rate     = ctrl_q[B_RATE_LSB +: 3]; // [RULE6]
    assign chan_b_smooth_enable = ctrl_q[B_EN_BIT];        // [RULE7]

    // Ramp control register; writes are dropped once the lock is set.
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q <= RAMP_CTRL_RESET; // [RULE1]
        end else if (wr_ctrl && !lock_q) begin // [RULE8]
            ctrl_q <= wdata;
        end
    end

    // Lock bit is write-one-to-set and only reset clears it.
    always_ff @(posedge clk) begin
        if (rst) begin
            lock_q <= CFG_LOCK_RESET[LOCK_BIT];
        end else if (wr_lock && wdata[LOCK_BIT]) begin
            lock_q <= 1'b1;
        end
    end

    // Read data stand for one cycle after the strobe, else zero.
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (rd && reg_hit(addr, RAMP_CTRL_OFF)) begin
            rdata_q <= ctrl_q;
        end else if (rd && reg_hit(addr, CFG_LOCK_OFF)) begin
            rdata_q <= {7'h00, lock_q};
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // Time slot counter giving one tick per slot to both channels.
    always_ff @(posedge clk) begin
        if (rst) begin
            slot_cnt_q <= '0;
            tick_q     <= 1'b0;
        end else if (slot_cnt_q >= CNT_W'(STEP_CYCLES - 1)) begin
            slot_cnt_q <= '0;
            tick_q     <= 1'b1;
        end else begin
            slot_cnt_q <= slot_cnt_q + 1'b1;
            tick_q     <= 1'b0;
        end
    end

    // Channel settings: index 0 drives output b, index 1 drives output c.
    assign ch_if[0].target = target_b;
    assign ch_if[0].rate   = chan_b_ramp_rate;
    assign ch_if[0].enable = chan_b_smooth_enable;
    assign ch_if[1].target = target_c;
    assign ch_if[1].rate   = chan_c_ramp_rate;
    assign ch_if[1].enable = chan_c_smooth_enable;

    // Both channels share the slot tick and the same ramp engine.
    for (genvar i = 0; i < 2; i++) begin : g_chan
        assign ch_if[i].tick = tick_q;
        ramp_channel u_chan (
            .clk (clk),
            .rst (rst),
            .ch  (ch_if[i].chan)
        );
    end

    // Outputs come from the channel duty flops and local registers.
    assign fan_drive_b = ch_if[0].duty;
    assign fan_drive_c = ch_if[1].duty;
    assign rdata       = rdata_q;
    assign cfg_locked  = lock_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_reset_clears: assert property ( // [RULE1]
        @(posedge clk) disable iff (1'b0)
        rst |=> ctrl_q == 8'h00 && fan_drive_b == 8'h00
            && fan_drive_c == 8'h00)
        else $error("Reset did not clear control and duties.");

    a_write_lands: assert property ( // [RULE8]
        wr_ctrl && !lock_q |=> ctrl_q == $past(wdata))
        else $error("Unlocked write did not land.");

    a_lock_blocks: assert property ( // [RULE8]
        lock_q |=> $stable(ctrl_q) && lock_q)
        else $error("Locked register changed.");

    a_read_back: assert property (
        rd && reg_hit(addr, RAMP_CTRL_OFF) |=> rdata == $past(ctrl_q)
        ##1 ($past(rd) || rdata == 8'h00))
        else $error("Read data wrong or held too long.");

    a_c_bypass: assert property ( // [RULE5]
        !ctrl_q[3] && !(wr_ctrl && !lock_q)
        |=> fan_drive_c == $past(target_c))
        else $error("Channel c not immediate while disabled.");

    a_b_bypass: assert property ( // [RULE7]
        !ctrl_q[7] && !(wr_ctrl && !lock_q)
        |=> fan_drive_b == $past(target_b))
        else $error("Channel b not immediate while disabled.");

    a_c_rate_field: assert property ( // [RULE2]
        ctrl_q[3] && tick_q && target_c > fan_drive_c
            && target_c - fan_drive_c > 8'h30
        |=> fan_drive_c == $past(fan_drive_c)
            + rate_step($past(ctrl_q[2:0])))
        else $error("Channel c step ignores bits two to zero.");

    a_b_rate_field: assert property ( // [RULE6]
        ctrl_q[7] && tick_q && target_b > fan_drive_b
            && target_b - fan_drive_b > 8'h30
        |=> fan_drive_b == $past(fan_drive_b)
            + rate_step($past(ctrl_q[6:4])))
        else $error("Channel b step ignores bits six to four.");

    a_tick_single: assert property (
        tick_q |=> !tick_q)
        else $error("Slot tick longer than one cycle.");

    a_tick_spacing: assert property (
        tick_q |-> $past(slot_cnt_q) == CNT_W'(STEP_CYCLES - 1))
        else $error("Slot tick came after a wrong count.");

    a_cnt_bound: assert property (
        slot_cnt_q < CNT_W'(STEP_CYCLES))
        else $error("Slot counter ran past the slot length.");

    // Register bus checks on the lock, the control register writes and the read port.
    a_lock_sets: assert property ( // [RULE8]
        wr_lock && wdata[LOCK_BIT] |=> lock_q)
        else $error("Writing one did not set the lock.");

    a_lock_keep: assert property (
        !lock_q && !(wr_lock && wdata[LOCK_BIT]) |=> !lock_q)
        else $error("Lock set without a write of one.");

    a_locked_ignored: assert property ( // [RULE8]
        wr_ctrl && lock_q |=> $stable(ctrl_q))
        else $error("Write landed while locked.");

    a_other_write: assert property (
        wr && !reg_hit(addr, RAMP_CTRL_OFF) |=> $stable(ctrl_q))
        else $error("Write elsewhere changed ramp control.");

    a_write_enables: assert property ( // [RULE5] [RULE7]
        wr_ctrl && !lock_q
        |=> chan_c_smooth_enable == $past(wdata[3])
            && chan_b_smooth_enable == $past(wdata[7]))
        else $error("Enable bits taken from wrong positions.");

    a_write_rates: assert property ( // [RULE2] [RULE6]
        wr_ctrl && !lock_q
        |=> chan_c_ramp_rate == $past(wdata[2:0])
            && chan_b_ramp_rate == $past(wdata[6:4]))
        else $error("Rate fields taken from wrong positions.");

    a_read_lock: assert property (
        rd && reg_hit(addr, CFG_LOCK_OFF)
        |=> rdata == {7'h00, $past(lock_q)})
        else $error("Lock read back wrong.");

    a_read_unmapped: assert property (
        rd && !reg_hit(addr, RAMP_CTRL_OFF) && !reg_hit(addr, CFG_LOCK_OFF)
        |=> rdata == 8'h00)
        else $error("Unmapped read returned nonzero data.");

    a_rdata_idle: assert property (
        !rd |=> rdata == 8'h00)
        else $error("Read data stood without a read.");

    // Channel c checks seen at the output pins.
    a_c_rate_down: assert property ( // [RULE2]
        ctrl_q[3] && tick_q && fan_drive_c > target_c
            && fan_drive_c - target_c > 8'h30
        |=> fan_drive_c == $past(fan_drive_c)
            - rate_step($past(ctrl_q[2:0])))
        else $error("Channel c down step ignores bits two to zero.");

    a_c_lands: assert property ( // [RULE3]
        ctrl_q[3] && tick_q && target_c >= fan_drive_c
            && target_c - fan_drive_c <= rate_step(ctrl_q[2:0])
        |=> fan_drive_c == $past(target_c))
        else $error("Channel c did not land on its target.");

    a_c_up: assert property ( // [RULE3]
        ctrl_q[3] && tick_q && target_c > fan_drive_c
        |=> fan_drive_c > $past(fan_drive_c))
        else $error("Channel c did not rise on a slot.");

    a_c_down: assert property ( // [RULE3]
        ctrl_q[3] && tick_q && target_c < fan_drive_c
        |=> fan_drive_c < $past(fan_drive_c))
        else $error("Channel c did not fall on a slot.");

    a_c_hold: assert property ( // [RULE3]
        ctrl_q[3] && !tick_q |=> $stable(fan_drive_c))
        else $error("Channel c moved between slots.");

    a_c_settled: assert property ( // [RULE3]
        ctrl_q[3] && tick_q && fan_drive_c == target_c
        |=> fan_drive_c == $past(fan_drive_c))
        else $error("Channel c left a reached target.");

    // Channel b checks seen at the output pins.
    a_b_rate_down: assert property ( // [RULE6]
        ctrl_q[7] && tick_q && fan_drive_b > target_b
            && fan_drive_b - target_b > 8'h30
        |=> fan_drive_b == $past(fan_drive_b)
            - rate_step($past(ctrl_q[6:4])))
        else $error("Channel b down step ignores bits six to four.");

    a_b_lands: assert property ( // [RULE3]
        ctrl_q[7] && tick_q && target_b >= fan_drive_b
            && target_b - fan_drive_b <= rate_step(ctrl_q[6:4])
        |=> fan_drive_b == $past(target_b))
        else $error("Channel b did not land on its target.");

    a_b_up: assert property ( // [RULE3]
        ctrl_q[7] && tick_q && target_b > fan_drive_b
        |=> fan_drive_b > $past(fan_drive_b))
        else $error("Channel b did not rise on a slot.");

    a_b_down: assert property ( // [RULE3]
        ctrl_q[7] && tick_q && target_b < fan_drive_b
        |=> fan_drive_b < $past(fan_drive_b))
        else $error("Channel b did not fall on a slot.");

    a_b_hold: assert property ( // [RULE3]
        ctrl_q[7] && !tick_q |=> $stable(fan_drive_b))
        else $error("Channel b moved between slots.");

    a_b_settled: assert property ( // [RULE3]
        ctrl_q[7] && tick_q && fan_drive_b == target_b
        |=> fan_drive_b == $past(fan_drive_b))
        else $error("Channel b left a reached target.");

    c_locked_write: cover property (lock_q && wr_ctrl);
    c_c_ramping: cover property (ctrl_q[3] && tick_q
        && fan_drive_c != target_c);
    c_b_ramping: cover property (ctrl_q[7] && tick_q
        && fan_drive_b != target_b);
    c_reg_read: cover property (rd && addr == RAMP_CTRL_OFF);
    c_c_ramp_down: cover property (ctrl_q[3] && tick_q
        && fan_drive_c > target_c);

endmodule : fan_pwm_acoustic_ramp
`default_nettype wire

// File: fan_pwm_acoustic_ramp_tb.sv
`timescale 1ns/10ps
`default_nettype none
module fan_pwm_acoustic_ramp_tb;
    import fan_ramp_pkg::*;
    logic       clk, rst, wr, rd, mb, mc, locked;
    logic [7:0] addr, wdata, rdata;
    duty_t      tb, tc, db, dc, sb, sc;
    int         n_errors, checks;
    localparam duty_t STEPS [8] = '{8'h01, 8'h02, 8'h03, 8'h05,
                                    8'h08, 8'h0C, 8'h18, 8'h30};

    fan_pwm_acoustic_ramp #(.STEP_CYCLES(4)) u_dut (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .target_b(tb), .target_c(tc),
        .fan_drive_b(db), .fan_drive_c(dc), .cfg_locked(locked));
    fan_model u_fan_b (.clk(clk), .rst(rst), .duty(db),
                       .step_seen(sb), .moved(mb));
    fan_model u_fan_c (.clk(clk), .rst(rst), .duty(dc),
                       .step_seen(sc), .moved(mc));

    // Free-running system clock.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    task rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : rd_reg

    task stop_test;
        $display("checks=%0d errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : stop_test

    task test_regs;
        logic [7:0] d;
        rd_reg(RAMP_CTRL_OFF, d);
        chk(d, 8'h00);
        chk({7'h00, locked}, 8'h00);
        wr_reg(RAMP_CTRL_OFF, 8'hA5);
        rd_reg(RAMP_CTRL_OFF, d);
        chk(d, 8'hA5);
        rd_reg(8'h10, d);
        chk(d, 8'h00);
        wr_reg(RAMP_CTRL_OFF, 8'h77);
        @(posedge clk);
        tb <= 8'h5A;
        tc <= 8'hC3;
        repeat (2) @(negedge clk);
        chk(db, 8'h5A);
        chk(dc, 8'hC3);
        $display("test_regs done");
    endtask : test_regs

    // Follow the watched output until it sits on tgt, step by step.
    task track(input bit b, input duty_t tgt, input duty_t st,
               inout duty_t cur);
        duty_t e;
        for (int i = 0; i < 1000 && cur !== tgt; i++) begin
            @(negedge clk);
            if (b ? mb : mc) begin
                e = (tgt > cur) ? tgt - cur : cur - tgt;
                if (e > st) e = st;
                chk(b ? sb : sc, e);
                cur = (tgt > cur) ? cur + e : cur - e;
            end
        end
        chk(b ? db : dc, tgt);
    endtask : track

    task test_ramp(input bit b, input rate_code_t code);
        duty_t cur;
        logic [7:0] cfg;
        wr_reg(RAMP_CTRL_OFF, 8'h00);
        @(posedge clk);
        tb <= 8'h00;
        tc <= 8'h00;
        repeat (3) @(negedge clk);
        cur = 8'h00;
        cfg = b ? {1'b1, code, 4'h7} : {4'h7, 1'b1, code};
        wr_reg(RAMP_CTRL_OFF, cfg);
        @(posedge clk);
        tb <= 8'h64;
        tc <= 8'h64;
        track(b, 8'h64, STEPS[code], cur);
        chk(b ? dc : db, 8'h64);
        @(posedge clk);
        tb <= 8'h10;
        tc <= 8'h10;
        track(b, 8'h10, STEPS[code], cur);
        $display("test_ramp %0d %0d done", b, code);
    endtask : test_ramp

    task test_lock;
        logic [7:0] d;
        wr_reg(RAMP_CTRL_OFF, 8'h3C);
        wr_reg(CFG_LOCK_OFF, 8'h01);
        @(negedge clk);
        chk({7'h00, locked}, 8'h01);
        rd_reg(CFG_LOCK_OFF, d);
        chk(d, 8'h01);
        wr_reg(RAMP_CTRL_OFF, 8'hC3);
        rd_reg(RAMP_CTRL_OFF, d);
        chk(d, 8'h3C);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        rd_reg(RAMP_CTRL_OFF, d);
        chk(d, 8'h00);
        chk({7'h00, locked}, 8'h00);
        $display("test_lock done");
    endtask : test_lock

    // Main sequence: reset, then every scenario in turn.
    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        tb = 8'h00;
        tc = 8'h00;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        test_regs;
        for (int k = 0; k < 8; k++) begin
            test_ramp(1'b0, rate_code_t'(k));
            test_ramp(1'b1, rate_code_t'(k));
        end
        test_lock;
        stop_test;
    end

    // Watchdog against a hung run.
    initial begin
        repeat (30000) @(posedge clk);
        n_errors++;
        stop_test;
    end
endmodule : fan_pwm_acoustic_ramp_tb
`default_nettype wire

// File: fan_ramp_pkg.sv
`default_nettype none
package fan_ramp_pkg;

    // Register map; the lock register's offset is a local choice.
    localparam logic [7:0] RAMP_CTRL_OFF   = 8'h63;
    localparam logic [7:0] CFG_LOCK_OFF    = 8'h7E;
    localparam logic [7:0] RAMP_CTRL_RESET = 8'h00;
    localparam logic [7:0] CFG_LOCK_RESET  = 8'h00;

    // Field positions inside the ramp control register.
    localparam int C_RATE_LSB = 0;
    localparam int C_EN_BIT   = 3;
    localparam int B_RATE_LSB = 4;
    localparam int B_EN_BIT   = 7;
    localparam int LOCK_BIT   = 0;

    // One ramp time slot; 35 s over 171 steps of one code is about 205 ms.
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned SLOT_TIME_NS  = 205_000_000;
    localparam int unsigned SLOT_CYCLES   = SLOT_TIME_NS / CLK_PERIOD_NS;

    typedef logic [2:0] rate_code_t;
    typedef logic [7:0] duty_t;

    // Duty change per time slot for each ramp code, rising or falling.
    function automatic duty_t rate_step(input rate_code_t code);
        case (code)
            3'h0:    rate_step = 8'h01;
            3'h1:    rate_step = 8'h02;
            3'h2:    rate_step = 8'h03;
            3'h3:    rate_step = 8'h05;
            3'h4:    rate_step = 8'h08;
            3'h5:    rate_step = 8'h0C;
            3'h6:    rate_step = 8'h18;
            default: rate_step = 8'h30;
        endcase
    endfunction : rate_step

endpackage : fan_ramp_pkg
`default_nettype wire

// File: ramp_ch_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ramp_ch_if;
    import fan_ramp_pkg::*;
    duty_t      target;
    duty_t      duty;
    rate_code_t rate;
    logic       enable;
    logic       tick;

    // The controller feeds settings and the slot tick; the channel answers.
    modport ctrl (output target, rate, enable, tick, input duty);
    modport chan (input target, rate, enable, tick, output duty);
endinterface : ramp_ch_if
`default_nettype wire

// File: ramp_channel.sv
`timescale 1ns/10ps
`default_nettype none
module ramp_channel (
    input  wire logic clk,
    input  wire logic rst,
    ramp_ch_if.chan   ch
);
    import fan_ramp_pkg::*;

    duty_t duty_q;
    duty_t duty_d;
    duty_t step;

    assign step    = rate_step(ch.rate);
    assign ch.duty = duty_q;

    // Next duty: follow the target at once, or step toward it per slot.
    always_comb begin
        duty_d = duty_q;
        if (!ch.enable) begin
            duty_d = ch.target; // [RULE9]
        end else if (ch.tick) begin
            if (duty_q < ch.target) begin
                if (ch.target - duty_q <= step) begin
                    duty_d = ch.target;
                end else begin
                    duty_d = duty_q + step; // [RULE3] [RULE4]
                end
            end else if (duty_q > ch.target) begin
                if (duty_q - ch.target <= step) begin
                    duty_d = ch.target;
                end else begin
                    duty_d = duty_q - step; // [RULE3] [RULE4]
                end
            end
        end
    end

    // Duty register; starts at zero, then takes the target at once while smoothing is off after reset.
    always_ff @(posedge clk) begin
        if (rst) begin
            duty_q <= 8'h00;
        end else begin
            duty_q <= duty_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_bypass_follows: assert property ( // [RULE9]
        !ch.enable |=> duty_q == $past(ch.target))
        else $error("Disabled channel did not follow target.");

    a_step_up_size: assert property ( // [RULE4]
        ch.enable && ch.tick && duty_q < ch.target
            && (ch.target - duty_q) > step
        |=> duty_q == $past(duty_q) + $past(step))
        else $error("Upward ramp step has wrong size.");

    a_step_down_size: assert property ( // [RULE4]
        ch.enable && ch.tick && duty_q > ch.target
            && (duty_q - ch.target) > step
        |=> duty_q == $past(duty_q) - $past(step))
        else $error("Downward ramp step has wrong size.");

    a_hold_between: assert property ( // [RULE3]
        ch.enable && !ch.tick |=> $stable(duty_q))
        else $error("Ramping duty moved outside a time slot.");

    a_no_overshoot: assert property ( // [RULE3]
        ch.enable && ch.tick && duty_q <= ch.target
        |=> duty_q <= $past(ch.target))
        else $error("Ramping duty overshot its target.");

endmodule : ramp_channel
`default_nettype wire
